// ===== dv/host_ctrl_model.sv
// two-wire bus master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model
(
  input  wire logic clock_i,
  input  wire logic sda_line_i,
  output var logic  scl_o,
  output var logic  sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic power_up();
    tick(20000);
  endtask
  // 20 clocks low, 20 high; data moves mid-low
  task automatic one_bit(input logic b, output logic r);
    tick(10);
    sda_o <= b;
    tick(10);
    scl_o <= 1'b1;
    tick(10);
    r = sda_line_i;
    tick(10);
    scl_o <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      one_bit(tx[i], r);
      rx[i] = r;
    end
    one_bit(1'b1, ack);
  endtask
  task automatic start_f();
    tick(10);
    sda_o <= 1'b0;
    tick(10);
    scl_o <= 1'b0;
  endtask
  task automatic stop_f();
    tick(10);
    sda_o <= 1'b0;
    tick(10);
    scl_o <= 1'b1;
    tick(10);
    sda_o <= 1'b1;
    tick(10);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] ptr, input logic [23:0] d,
                    input int n, output int acks);
    logic [7:0] rx;
    logic k;
    start_f();
    xfer({a, 1'b0}, rx, k);
    acks = int'(!k);
    xfer(ptr, rx, k);
    acks += int'(!k);
    for (int i = 0; i < n; i++)
    begin
      xfer(d[23 - 8 * i -: 8], rx, k);
      acks += int'(!k);
    end
    stop_f();
  endtask
  // first status byte acked by the master, second one nacked
  task automatic rd(input logic [6:0] a, output logic [15:0] data);
    logic [7:0] rx;
    logic k;
    start_f();
    xfer({a, 1'b1}, rx, k);
    for (int i = 15; i >= 8; i--)
    begin
      one_bit(1'b1, k);
      data[i] = k;
    end
    one_bit(1'b0, k);
    xfer(8'hff, rx, k);
    data[7:0] = rx;
    stop_f();
  endtask
endmodule // host_ctrl_model
`default_nettype wire

// ===== dv/tuner_cfg_regs_monitor.sv
// assertion checker for the tuner configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tuner_cfg_regs_monitor
(
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic       scl_i,
  input wire logic       ref_prebias_start_i,
  input wire logic       lo_prebias_start_i,
  input wire logic [1:0] auto_pump_code_i,
  input wire logic [2:0] filter_center_trim_o,
  input wire logic       filter_trim_source_o,
  input wire logic       mixer_disable_o,
  input wire logic       pump_force_source_o,
  input wire logic       pump_force_sink_o,
  input wire logic       pump_force_hiz_o,
  input wire logic       power_detect_output_o,
  input wire logic       test_ndiv_route_o,
  input wire logic       test_rdiv_route_o,
  input wire logic       test_lo_route_o,
  input wire logic [1:0] pump_current_code_o,
  input wire logic       pump_current_auto_o,
  input wire logic       prebias_enable_o,
  input wire logic       ref_prebias_o,
  input wire logic       lo_prebias_o,
  input wire logic       oscillator_autoselect_enable_o,
  input wire logic       tune_adc_latch_o,
  input wire logic       tune_adc_read_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic [8:0] ref_run;
  logic [8:0] lo_run;
  // length of each prebias window, restarted by an accepted start
  always @(posedge clock_i)
  begin
    if (sys_rst_i || (ref_prebias_start_i && prebias_enable_o))
      ref_run <= 9'h000;
    else if (ref_prebias_o)
      ref_run <= ref_run + 9'h001;
    if (sys_rst_i || (lo_prebias_start_i && prebias_enable_o))
      lo_run <= 9'h000;
    else if (lo_prebias_o)
      lo_run <= lo_run + 9'h001;
  end
  sequence s_ref_go;
    ref_prebias_start_i && prebias_enable_o;
  endsequence
  property p_ref_go;
    s_ref_go |=> ref_prebias_o;
  endproperty
  a_ref_go: assert property (p_ref_go) else $error("ref prebias not started");
  property p_ref_cause;
    $rose(ref_prebias_o) |-> $past(ref_prebias_start_i) && $past(prebias_enable_o);
  endproperty
  a_ref_cause: assert property (p_ref_cause) else $error("ref prebias without start");
  property p_lo_cause;
    $rose(lo_prebias_o) |-> $past(lo_prebias_start_i) && $past(prebias_enable_o);
  endproperty
  a_lo_cause: assert property (p_lo_cause) else $error("lo prebias without start");
  property p_ref_width;
    $fell(ref_prebias_o) |-> ref_run == 9'h038 || ref_run == 9'h082;
  endproperty
  a_ref_width: assert property (p_ref_width) else $error("ref prebias width");
  property p_lo_width;
    $fell(lo_prebias_o) |-> lo_run == 9'h064 || lo_run == 9'h0c8;
  endproperty
  a_lo_width: assert property (p_lo_width) else $error("lo prebias width");
  property p_probe_onehot;
    $onehot0({pump_force_source_o, pump_force_sink_o, pump_force_hiz_o, power_detect_output_o,
              test_ndiv_route_o, test_rdiv_route_o, test_lo_route_o});
  endproperty
  a_probe_onehot: assert property (p_probe_onehot) else $error("probe decode");
  property p_adc_gate;
    oscillator_autoselect_enable_o && $past(oscillator_autoselect_enable_o) && !$past(sys_rst_i)
      |-> !tune_adc_latch_o && !tune_adc_read_o;
  endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("adc enable under autoselect");
  property p_pump_auto;
    pump_current_auto_o && $past(pump_current_auto_o) && !$past(sys_rst_i)
      |-> pump_current_code_o == $past(auto_pump_code_i);
  endproperty
  a_pump_auto: assert property (p_pump_auto) else $error("auto pump code");
  property p_field_on_low;
    !$stable({filter_center_trim_o, filter_trim_source_o, mixer_disable_o}) && !$past(sys_rst_i)
      |-> !scl_i;
  endproperty
  a_field_on_low: assert property (p_field_on_low) else $error("field change off ack");
endmodule // tuner_cfg_regs_monitor
bind tuner_cfg_regs tuner_cfg_regs_monitor i_tuner_cfg_regs_monitor (.*);
`default_nettype wire

// ===== dv/tuner_pll_test_config_regs_bench.sv
// self-checking bench for the tuner configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tuner_pll_test_config_regs_bench;
  localparam logic [6:0] ADDR = 7'h60;
  logic       clock_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       ref_prebias_start_i = 1'b0;
  logic       lo_prebias_start_i = 1'b0;
  logic       vco_search_busy_i = 1'b0;
  logic       vco_search_ok_i = 1'b0;
  logic [1:0] auto_pump_code_i = 2'h0;
  logic [7:0] t_reg = 8'h10;
  logic [7:0] p_reg = 8'hf1;
  logic [7:0] v_reg = 8'hd8;
  logic [15:0] rd_data;
  logic       samp = 1'b0;
  logic [25:0] notes[$];
  int         bad_count = 0;
  int         n_tests = 0;
  int         acks;
  logic [8:0] rc, lc;
  int unsigned seed_v;
  wire scl_i, sda_i, sda_o, sda_oe_n_o, host_scl, host_sda;
  wire [2:0] filter_center_trim_o, sub_band_select_o;
  wire [1:0] pump_current_code_o, oscillator_select_o;
  wire filter_trim_source_o, mixer_disable_o, pump_force_source_o, pump_force_sink_o;
  wire pump_force_hiz_o, power_detect_output_o, test_ndiv_route_o, test_rdiv_route_o;
  wire test_lo_route_o, pump_current_auto_o, prebias_enable_o, ref_prebias_o, lo_prebias_o;
  wire pump_on_time_o, oscillator_autoselect_enable_o, tune_adc_latch_o, tune_adc_read_o;
  wire autoselect_time_current_o;
  wire [25:0] obs = {filter_center_trim_o, filter_trim_source_o, mixer_disable_o,
    pump_force_source_o, pump_force_sink_o, pump_force_hiz_o, power_detect_output_o,
    test_ndiv_route_o, test_rdiv_route_o, test_lo_route_o, pump_current_code_o,
    pump_current_auto_o, prebias_enable_o, pump_on_time_o, oscillator_autoselect_enable_o,
    oscillator_select_o, sub_band_select_o, tune_adc_latch_o, tune_adc_read_o,
    autoselect_time_current_o};
  // open-drain data line with pull-up
  assign scl_i = host_scl;
  assign sda_i = host_sda & (sda_oe_n_o | sda_o);
  tuner_cfg_regs #(.DEV_ADDR(ADDR)) i_tuner_cfg_regs (.*);
  host_ctrl_model i_host_ctrl_model (.clock_i(clock_i), .sda_line_i(sda_i),
    .scl_o(host_scl), .sda_o(host_sda));
  initial
  begin
    forever #2.5 clock_i = ~clock_i;
  end
  // ************************
  // checking
  // ************************
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [25:0] exp_vec();
    logic [6:0] hot;
    hot = (t_reg[2:0] == 3'h0) ? 7'h00 : (7'h40 >> (t_reg[2:0] - 3'h1));
    return {t_reg[7:3], hot, p_reg[5] ? auto_pump_code_i : p_reg[7:6], p_reg[5], p_reg[4],
            p_reg[1], p_reg[0], v_reg[7:3], v_reg[2] & ~p_reg[0], v_reg[1] & ~p_reg[0],
            v_reg[0]};
  endfunction
  task automatic note();
    repeat (8) @(posedge clock_i);
    notes.push_back(exp_vec());
    samp <= 1'b1;
    @(posedge clock_i);
    samp <= 1'b0;
  endtask
  always @(posedge clock_i)
  begin
    if (samp && notes.size() > 0)
      check(obs, notes.pop_front());
  end
  initial
  begin
    repeat (100000) @(posedge clock_i);
    bad_count++;
    end_sim();
  end
  // ************************
  // scenarios
  // ************************
  initial
  begin
    seed_v = $urandom(92198);
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    note();
    i_host_ctrl_model.power_up();
    for (int c = 0; c < 8; c++)
    begin
      t_reg = {5'($urandom), 3'(c)};
      i_host_ctrl_model.wr(ADDR, 8'h00, {t_reg, 16'h0}, 1, acks);
      check(26'(acks), 26'h3);
      note();
    end
    for (int i = 0; i < 8; i++)
    begin
      auto_pump_code_i <= 2'($urandom);
      t_reg = 8'($urandom);
      p_reg = {2'(i), 1'(i >> 2), 5'($urandom)};
      v_reg = 8'($urandom);
      i_host_ctrl_model.wr(ADDR, 8'h00, {t_reg, p_reg, v_reg}, 3, acks);
      check(26'(acks), 26'h5);
      note();
    end
    // unmapped pointer is acked and dropped; foreign address is ignored
    i_host_ctrl_model.wr(ADDR, 8'h03, {8'($urandom), 16'h0}, 1, acks);
    check(26'(acks), 26'h3);
    i_host_ctrl_model.wr(ADDR ^ 7'h01, 8'h00, 24'h0, 1, acks);
    check(26'(acks), 26'h0);
    note();
    for (int k = 0; k < 3; k++)
    begin
      p_reg = {3'h0, 1'(k < 2), 1'(k), 1'(k), 2'h0};
      v_reg = 8'h06;
      i_host_ctrl_model.wr(ADDR, 8'h01, {p_reg, v_reg, 8'h0}, 2, acks);
      note();
      ref_prebias_start_i <= 1'b1;
      lo_prebias_start_i <= 1'b1;
      @(posedge clock_i);
      ref_prebias_start_i <= 1'b0;
      lo_prebias_start_i <= 1'b0;
      rc = 9'h000;
      lc = 9'h000;
      repeat (300)
      begin
        @(negedge clock_i);
        rc += 9'(ref_prebias_o);
        lc += 9'(lo_prebias_o);
      end
      check(26'(rc), 26'(k == 2 ? 0 : (k == 1 ? 130 : 56)));
      check(26'(lc), 26'(k == 2 ? 0 : (k == 1 ? 200 : 100)));
    end
    p_reg = 8'h01;
    i_host_ctrl_model.wr(ADDR, 8'h01, {p_reg, 16'h0}, 1, acks);
    vco_search_ok_i <= 1'b1;
    note();
    i_host_ctrl_model.rd(ADDR, rd_data);
    check({10'h0, rd_data}, 26'h0707);
    i_host_ctrl_model.rd(ADDR, rd_data);
    check({10'h0, rd_data}, 26'h0303);
    vco_search_busy_i <= 1'b1;
    i_host_ctrl_model.rd(ADDR, rd_data);
    check({10'h0, rd_data}, 26'h0000);
    end_sim();
  end
endmodule // tuner_pll_test_config_regs_bench
`default_nettype wire

// ===== hdl/pin_filter.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_filter
(
  input  wire clock_i,
  input  wire sys_rst_i,
  input  wire pin_i,
  output wire level_o
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg level_reg;

  // ***************
  // sync and filter
  // ***************
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      level_reg <= 1'b1;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
      begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level_o = level_reg;

endmodule // pin_filter

`default_nettype wire

// ===== hdl/probe_decode.v
// decodes the diagnostic probe code into registered one-hot controls
`timescale 1ns/1ps
`default_nettype none
`include "tuner_cfg_map.vh"

module probe_decode
(
  input  wire       clock_i,
  input  wire       sys_rst_i,
  input  wire [2:0] code_i,
  output reg        force_source_o,
  output reg        force_sink_o,
  output reg        force_hiz_o,
  output reg        power_detect_output_route_o,
  output reg        ndiv_route_o,
  output reg        rdiv_route_o,
  output reg        lo_route_o
);

  // ***************
  // decode
  // ***************
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      force_source_o <= 1'b0;
      force_sink_o   <= 1'b0;
      force_hiz_o    <= 1'b0;
      power_detect_output_route_o <= 1'b0;
      ndiv_route_o   <= 1'b0;
      rdiv_route_o   <= 1'b0;
      lo_route_o     <= 1'b0;
    end
    else
    begin
      force_source_o <= (code_i == `PROBE_SOURCE);
      force_sink_o   <= (code_i == `PROBE_SINK);
      force_hiz_o    <= (code_i == `PROBE_HIZ);
      power_detect_output_route_o <= (code_i == `PROBE_POWER_DETECT_OUTPUT);
      ndiv_route_o   <= (code_i == `PROBE_NDIV);
      rdiv_route_o   <= (code_i == `PROBE_RDIV);
      lo_route_o     <= (code_i == `PROBE_LO);
    end
  end

endmodule // probe_decode

`default_nettype wire

// ===== hdl/tuner_cfg_map.vh
// offsets, field positions, reset values and timing counts of the config bank
`ifndef TUNER_CFG_MAP_VH
`define TUNER_CFG_MAP_VH

// ***************
// register offsets
// ***************
`define OFS_TEST_DIAG   8'h00
`define OFS_SYNTH_PUMP  8'h01
`define OFS_OSC_BAND    8'h02

// ***************
// reset values
// ***************
`define RST_TEST_DIAG   8'h10
`define RST_SYNTH_PUMP  8'hf1
`define RST_OSC_BAND    8'hd8

// ***************
// test_diag_config fields
// ***************
`define F_TRIM_HI       7
`define F_TRIM_LO       5
`define F_TRIM_SRC      4
`define F_MIX_DIS       3
`define F_PROBE_HI      2
`define F_PROBE_LO      0

// ***************
// synth_pump_config fields
// ***************
`define F_PUMP_HI       7
`define F_PUMP_LO       6
`define F_PUMP_AUTO     5
`define F_PB_EN         4
`define F_REF_PB        3
`define F_LO_PB         2
`define F_PUMP_TON      1
`define F_AUTOSEL       0

// ***************
// oscillator_band_config fields
// ***************
`define F_OSC_HI        7
`define F_OSC_LO        6
`define F_SUB_HI        5
`define F_SUB_LO        3
`define F_ADC_LATCH     2
`define F_ADC_READ      1
`define F_AS_CURRENT    0

// ***************
// probe select codes
// ***************
`define PROBE_NORMAL    3'h0
`define PROBE_SOURCE    3'h1
`define PROBE_SINK      3'h2
`define PROBE_HIZ       3'h3
`define PROBE_POWER_DETECT_OUTPUT    3'h4
`define PROBE_NDIV      3'h5
`define PROBE_RDIV      3'h6
`define PROBE_LO        3'h7

// ***************
// timing
// ***************
`define CLK_PERIOD_PS   5000
`define REF_PB_SHORT_NS 280
`define REF_PB_LONG_NS  650
`define LO_PB_SHORT_NS  500
`define LO_PB_LONG_NS   1000
`define REF_PB_SHORT_CYC ((`REF_PB_SHORT_NS * 1000) / `CLK_PERIOD_PS)
`define REF_PB_LONG_CYC  ((`REF_PB_LONG_NS * 1000) / `CLK_PERIOD_PS)
`define LO_PB_SHORT_CYC  ((`LO_PB_SHORT_NS * 1000) / `CLK_PERIOD_PS)
`define LO_PB_LONG_CYC   ((`LO_PB_LONG_NS * 1000) / `CLK_PERIOD_PS)

`endif

// ===== hdl/tuner_cfg_regs.v
// two-wire slave with test, pump and oscillator configuration registers
// Behaviour
// - trim bits 7:5 set filter centre
// - bit 4 picks factory or manual trim
// - bit 3 disables quadrature mixers
// - probe codes 0-3: normal, source, sink, hiz
// - probe codes 4-7: power detect, dividers, lo
// - bits 7:6 choose pump current
// - bit 5 makes pump current automatic
// - bit 4 enables pump prebias
// - reference prebias 280 or 650 ns
// - lo prebias 500 or 1000 ns
// - bit 1 sets pump on-time
// - bit 0 runs oscillator autoselect
// - oscillator select, also search start
// - sub-band select, also search start
// - adc latch only without autoselect
// - adc read only without autoselect
// - bit 0 doubles autoselect time current
// - readable autoselect success status bit
`timescale 1ns/1ps
`default_nettype none
`include "tuner_cfg_map.vh"

module tuner_cfg_regs
#(
  parameter [6:0] DEV_ADDR = 7'h60 // arbitrary bus address
)
(
  input  wire       clock_i,
  input  wire       sys_rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_n_o,
  input  wire       ref_prebias_start_i,
  input  wire       lo_prebias_start_i,
  input  wire       vco_search_busy_i,
  input  wire       vco_search_ok_i,
  input  wire [1:0] auto_pump_code_i,
  output wire [2:0] filter_center_trim_o,
  output wire       filter_trim_source_o,
  output wire       mixer_disable_o,
  output wire       pump_force_source_o,
  output wire       pump_force_sink_o,
  output wire       pump_force_hiz_o,
  output wire       power_detect_output_o,
  output wire       test_ndiv_route_o,
  output wire       test_rdiv_route_o,
  output wire       test_lo_route_o,
  output wire [1:0] pump_current_code_o,
  output wire       pump_current_auto_o,
  output wire       prebias_enable_o,
  output wire       ref_prebias_o,
  output wire       lo_prebias_o,
  output wire       pump_on_time_o,
  output wire       oscillator_autoselect_enable_o,
  output wire [1:0] oscillator_select_o,
  output wire [2:0] sub_band_select_o,
  output wire       tune_adc_latch_o,
  output wire       tune_adc_read_o,
  output wire       autoselect_time_current_o
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_WR   = 3'h3;
  localparam [2:0] ST_RD   = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;

  localparam integer REF_SHORT = `REF_PB_SHORT_CYC;
  localparam integer REF_LONG  = `REF_PB_LONG_CYC;
  localparam integer LO_SHORT  = `LO_PB_SHORT_CYC;
  localparam integer LO_LONG   = `LO_PB_LONG_CYC;

  wire       scl_f;
  wire       sda_f;
  reg        scl_q_reg;
  reg        sda_q_reg;
  reg  [2:0] state_reg;
  reg  [3:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] tx_reg;
  reg  [7:0] ptr_reg;
  reg        ptr_valid_reg;
  reg        rw_reg;
  reg        mack_reg;
  reg        sda_oe_n_reg;
  reg        power_cycled_reg;
  reg  [7:0] test_diag_reg;
  reg  [7:0] synth_pump_reg;
  reg  [7:0] osc_band_reg;
  reg        adc_latch_reg;
  reg        adc_read_reg;
  reg        success_reg;
  reg  [1:0] pump_eff_reg;
  wire       start_cond;
  wire       stop_cond;
  wire       scl_rise;
  wire       scl_fall;
  wire [7:0] status_byte;
  wire       autosel;

  // ***************
  // pin synchronisers
  // ***************
  pin_filter scl_filter
  (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (scl_i),
    .level_o   (scl_f)
  );

  pin_filter sda_filter
  (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (sda_i),
    .level_o   (sda_f)
  );

  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end
    else
    begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end

  assign start_cond = scl_f & scl_q_reg & sda_q_reg & ~sda_f;
  assign stop_cond  = scl_f & scl_q_reg & ~sda_q_reg & sda_f;
  assign scl_rise   = scl_f & ~scl_q_reg;
  assign scl_fall   = ~scl_f & scl_q_reg;

  // status byte: unused, pump code, power cycled, success, idle
  assign status_byte = {3'h0, pump_eff_reg, power_cycled_reg, success_reg,
                        ~vco_search_busy_i};

  // ***************
  // serial slave
  // ***************
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_reg        <= ST_IDLE;
      bit_cnt_reg      <= 4'h0;
      shift_reg        <= 8'h00;
      tx_reg           <= 8'h00;
      ptr_reg          <= 8'h00;
      ptr_valid_reg    <= 1'b0;
      rw_reg           <= 1'b0;
      mack_reg         <= 1'b0;
      sda_oe_n_reg     <= 1'b1;
      power_cycled_reg <= 1'b1;
      test_diag_reg    <= `RST_TEST_DIAG;
      synth_pump_reg   <= `RST_SYNTH_PUMP;
      osc_band_reg     <= `RST_OSC_BAND;
    end
    else if (start_cond)
    begin
      state_reg     <= ST_ADDR;
      bit_cnt_reg   <= 4'h0;
      ptr_valid_reg <= 1'b0;
      rw_reg        <= 1'b0;
      sda_oe_n_reg  <= 1'b1;
    end
    else if (stop_cond)
    begin
      state_reg    <= ST_IDLE;
      sda_oe_n_reg <= 1'b1;
      if (rw_reg)
      begin
        power_cycled_reg <= 1'b0;
      end
    end
    else
    begin
      case (state_reg)
        ST_ADDR, ST_WR:
        begin
          if (scl_rise)
          begin
            shift_reg   <= {shift_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == 4'h8)
          begin
            if (state_reg == ST_ADDR)
            begin
              if (shift_reg[7:1] == DEV_ADDR)
              begin
                rw_reg       <= shift_reg[0];
                sda_oe_n_reg <= 1'b0;
                state_reg    <= ST_ACK;
              end
              else
              begin
                state_reg <= ST_IDLE;
              end
            end
            else
            begin
              sda_oe_n_reg <= 1'b0;
              state_reg    <= ST_ACK;
              if (!ptr_valid_reg)
              begin
                ptr_reg       <= shift_reg;
                ptr_valid_reg <= 1'b1;
              end
              else
              begin
                ptr_reg <= ptr_reg + 8'h01;
                if (ptr_reg == `OFS_TEST_DIAG)
                begin
                  test_diag_reg <= shift_reg;
                end
                else if (ptr_reg == `OFS_SYNTH_PUMP)
                begin
                  synth_pump_reg <= shift_reg;
                end
                else if (ptr_reg == `OFS_OSC_BAND)
                begin
                  osc_band_reg <= shift_reg;
                end
              end
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg)
            begin
              tx_reg       <= status_byte;
              sda_oe_n_reg <= status_byte[7];
              state_reg    <= ST_RD;
            end
            else
            begin
              sda_oe_n_reg <= 1'b1;
              state_reg    <= ST_WR;
            end
          end
        end
        ST_RD:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7)
            begin
              sda_oe_n_reg <= 1'b1;
              state_reg    <= ST_RACK;
            end
            else
            begin
              tx_reg       <= {tx_reg[6:0], 1'b0};
              sda_oe_n_reg <= tx_reg[6];
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            mack_reg <= ~sda_f;
          end
          else if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            if (mack_reg)
            begin
              tx_reg       <= status_byte;
              sda_oe_n_reg <= status_byte[7];
              state_reg    <= ST_RD;
            end
            else
            begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default:
        begin
          sda_oe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // ***************
  // derived controls
  // ***************
  assign autosel = synth_pump_reg[`F_AUTOSEL];

  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      adc_latch_reg <= 1'b0;
      adc_read_reg  <= 1'b0;
      success_reg   <= 1'b0;
      pump_eff_reg  <= 2'h0;
    end
    else
    begin
      adc_latch_reg <= ~autosel & osc_band_reg[`F_ADC_LATCH];
      adc_read_reg  <= ~autosel & osc_band_reg[`F_ADC_READ];
      success_reg   <= autosel & ~vco_search_busy_i & vco_search_ok_i;
      if (synth_pump_reg[`F_PUMP_AUTO])
      begin
        pump_eff_reg <= auto_pump_code_i;
      end
      else
      begin
        pump_eff_reg <= synth_pump_reg[`F_PUMP_HI:`F_PUMP_LO];
      end
    end
  end

  // ***************
  // prebias timers
  // ***************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_pb
      wire       go;
      wire [7:0] len;
      reg  [7:0] cnt_reg;
      reg        active_reg;
      if (gi == 0)
      begin : g_ref
        assign go  = ref_prebias_start_i;
        assign len = synth_pump_reg[`F_REF_PB] ? REF_LONG[7:0] : REF_SHORT[7:0];
      end
      else
      begin : g_lo
        assign go  = lo_prebias_start_i;
        assign len = synth_pump_reg[`F_LO_PB] ? LO_LONG[7:0] : LO_SHORT[7:0];
      end
      always @(posedge clock_i)
      begin
        if (sys_rst_i)
        begin
          cnt_reg    <= 8'h00;
          active_reg <= 1'b0;
        end
        else if (go && synth_pump_reg[`F_PB_EN])
        begin
          cnt_reg    <= len - 8'h01;
          active_reg <= 1'b1;
        end
        else if (cnt_reg != 8'h00)
        begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        else
        begin
          active_reg <= 1'b0;
        end
      end
    end
  endgenerate

  // ***************
  // diagnostic decode
  // ***************
  probe_decode probe
  (
    .clock_i        (clock_i),
    .sys_rst_i      (sys_rst_i),
    .code_i         (test_diag_reg[`F_PROBE_HI:`F_PROBE_LO]),
    .force_source_o (pump_force_source_o),
    .force_sink_o   (pump_force_sink_o),
    .force_hiz_o    (pump_force_hiz_o),
    .power_detect_output_route_o (power_detect_output_o),
    .ndiv_route_o   (test_ndiv_route_o),
    .rdiv_route_o   (test_rdiv_route_o),
    .lo_route_o     (test_lo_route_o)
  );

  // ***************
  // outputs
  // ***************
  assign sda_o                          = 1'b0;
  assign sda_oe_n_o                     = sda_oe_n_reg;
  assign filter_center_trim_o           = test_diag_reg[`F_TRIM_HI:`F_TRIM_LO];
  assign filter_trim_source_o           = test_diag_reg[`F_TRIM_SRC];
  assign mixer_disable_o                = test_diag_reg[`F_MIX_DIS];
  assign pump_current_code_o            = pump_eff_reg;
  assign pump_current_auto_o            = synth_pump_reg[`F_PUMP_AUTO];
  assign prebias_enable_o               = synth_pump_reg[`F_PB_EN];
  assign ref_prebias_o                  = g_pb[0].active_reg;
  assign lo_prebias_o                   = g_pb[1].active_reg;
  assign pump_on_time_o                 = synth_pump_reg[`F_PUMP_TON];
  assign oscillator_autoselect_enable_o = autosel;
  assign oscillator_select_o            = osc_band_reg[`F_OSC_HI:`F_OSC_LO];
  assign sub_band_select_o              = osc_band_reg[`F_SUB_HI:`F_SUB_LO];
  assign tune_adc_latch_o               = adc_latch_reg;
  assign tune_adc_read_o                = adc_read_reg;
  assign autoselect_time_current_o      = osc_band_reg[`F_AS_CURRENT];

endmodule // tuner_cfg_regs

`default_nettype wire
